//--- core/usda_map.vh
// usda_map.vh: register offsets, field positions, reset values and timing counts
// assumes: included by the shadow data access design files
`ifndef USDA_MAP_VH
`define USDA_MAP_VH
`define USDA_OFS_SLOT7      32'h5000114c
`define USDA_OFS_SLOT8      32'h50001150
`define USDA_OFS_CTRL       32'h50001180
`define USDA_OFS_STAT       32'h50001184
`define USDA_ADDR_W         32
`define USDA_DATA_LSB       0
`define USDA_DATA_MSB       7
`define USDA_CTRL_FIFO_EN   0
`define USDA_CTRL_IR_MODE   1
`define USDA_STAT_DR        0
`define USDA_STAT_TRANSMIT_HOLDING_EMPTY_FLAG      5
`define USDA_STAT_OVR       1
`define USDA_CTRL_RST       32'h00000000
`define USDA_FIFO_DEPTH     16
`define USDA_BUF_DEPTH      32
`define USDA_BAUD_HZ        115200
`define USDA_CLK_HZ         40000000
`define USDA_BIT_CYC        (`USDA_CLK_HZ / `USDA_BAUD_HZ)
`endif

//--- core/usda_fifo.v
// usda_fifo.v: synchronous fifo with registered read data, valid/ready both sides
// assumes: single clock, synchronous active-low reset
`default_nettype none
module usda_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_sys_i,
  input  wire             reset_n_i,
  input  wire             flush_i,
  input  wire [AW:0]      limit_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output reg              out_valid_o,
  input  wire             out_ready_i,
  output reg  [WIDTH-1:0] out_data_o,
  output wire [AW:0]      count_o
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;
  // output register counts as one stored entry
  assign count_o    = cnt_r;
  assign in_ready_o = (cnt_r < limit_i);
  assign push       = in_valid_i & in_ready_o;
  assign pop        = (cnt_r != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i)
                      & ~(out_valid_o & ~out_ready_i);
  always @(posedge clk_sys_i) begin
    if (push)
      mem_r[wp_r] <= in_data_i;
  end
  always @(posedge clk_sys_i) begin
    if (!reset_n_i || flush_i) begin
      wp_r        <= {AW{1'b0}};
      rp_r        <= {AW{1'b0}};
      cnt_r       <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o  <= {WIDTH{1'b0}};
    end else begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (out_valid_o && out_ready_i)
        out_valid_o <= 1'b0;
      if (pop && (rp_r != wp_r || cnt_r > {{AW{1'b0}}, out_valid_o})) begin
        out_data_o  <= mem_r[rp_r];
        out_valid_o <= 1'b1;
        rp_r        <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push}
               - {{AW{1'b0}}, (out_valid_o & out_ready_i)};
    end
  end
endmodule // usda_fifo
`default_nettype wire

//--- core/usda_core.v
// usda_core.v: uart shadow data access path with axi4-lite slave and serial/ir line
// assumes: 40 MHz clk_sys_i, synchronous active-low reset, asynchronous line inputs
`default_nettype none
`include "usda_map.vh"
module usda_core #(
  parameter FIFO_DEPTH = `USDA_FIFO_DEPTH,
  parameter BIT_CYC    = `USDA_BIT_CYC
) (
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        serial_in_i,
  input  wire        ir_in_i,
  output reg         serial_out_o,
  output reg         ir_out_n_o
);
  localparam RXS_IDLE = 2'd0;
  localparam RXS_DATA = 2'd1;
  localparam RXS_STOP = 2'd2;
  localparam TXS_IDLE = 2'd0;
  localparam TXS_DATA = 2'd1;
  localparam TXS_STOP = 2'd2;
  localparam [31:0] BIT_W    = BIT_CYC;
  localparam [31:0] FDEP_W   = FIFO_DEPTH;
  // bit counters are 16 bits wide: bit times above 65535 clocks are not supported
  localparam [15:0] BIT_C    = BIT_W[15:0];
  localparam [15:0] HALF_C   = BIT_W[16:1];
  localparam [5:0]  FIFO_LIM = FDEP_W[5:0];

  function sel_slot;
    input [31:0] a;
    begin
      sel_slot = (a == `USDA_OFS_SLOT7) || (a == `USDA_OFS_SLOT8);
    end
  endfunction

  reg  [31:0] ctrl_r;
  reg         overrun_r;
  reg  [7:0]  rx_hold_r;
  reg         rx_hold_v_r;
  reg  [7:0]  tx_hold_r;
  reg         transmit_holding_empty_flag_r;
  wire        fifo_en = ctrl_r[`USDA_CTRL_FIFO_EN];
  wire        ir_mode = ctrl_r[`USDA_CTRL_IR_MODE];

  // line synchronisers: first stage only feeds second
  reg [1:0] ser_s_r;
  reg [1:0] ir_s_r;
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ser_s_r <= 2'b11;
      ir_s_r  <= 2'b11;
    end else begin
      ser_s_r <= {ser_s_r[0], serial_in_i};
      ir_s_r  <= {ir_s_r[0], ir_in_i};
    end
  end
  // ir input idles high, active-low pulses like the serial line
  wire rx_line = ir_mode ? ir_s_r[1] : ser_s_r[1];

  // receiver
  reg [1:0]  rx_st_r;
  reg [15:0] rx_cnt_r;
  reg [2:0]  rx_bit_r;
  reg [7:0]  rx_sh_r;
  reg        rx_done_r;
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rx_st_r   <= RXS_IDLE;
      rx_cnt_r  <= 16'h0000;
      rx_bit_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      case (rx_st_r)
        RXS_IDLE: begin
          if (!rx_line) begin
            rx_cnt_r <= HALF_C + BIT_C - 16'h0001;
            rx_bit_r <= 3'h0;
            rx_st_r  <= RXS_DATA;
          end
        end
        RXS_DATA: begin
          if (rx_cnt_r != 16'h0000)
            rx_cnt_r <= rx_cnt_r - 16'h0001;
          else begin
            rx_sh_r  <= {rx_line, rx_sh_r[7:1]};
            rx_cnt_r <= BIT_C - 16'h0001;
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == 3'h7)
              rx_st_r <= RXS_STOP;
          end
        end
        RXS_STOP: begin
          if (rx_cnt_r != 16'h0000)
            rx_cnt_r <= rx_cnt_r - 16'h0001;
          else begin
            rx_done_r <= 1'b1;
            rx_st_r   <= RXS_IDLE;
          end
        end
        default: rx_st_r <= RXS_IDLE;
      endcase
    end
  end

  // axi read/write decode
  wire       aw_hit = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire       wr_go  = aw_hit & ~s_axi_awready;
  wire       wr_slot = wr_go & sel_slot(s_axi_awaddr) & s_axi_wstrb[0];
  wire       rd_go  = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
  wire       rd_slot = rd_go & sel_slot(s_axi_araddr);

  // receive fifo
  wire       rxf_in_ready;
  wire       rxf_valid;
  wire [7:0] rxf_data;
  wire       rxf_pop = rd_slot & fifo_en & rxf_valid;
  usda_fifo #(.WIDTH(8), .DEPTH(`USDA_BUF_DEPTH), .AW(5)) u_rx_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .flush_i     (~fifo_en),
    .limit_i     (FIFO_LIM),
    .in_valid_i  (rx_done_r & fifo_en),
    .in_ready_o  (rxf_in_ready),
    .in_data_i   (rx_sh_r),
    .out_valid_o (rxf_valid),
    .out_ready_i (rxf_pop),
    .out_data_o  (rxf_data),
    .count_o     ()
  );

  // transmit fifo
  reg        txf_take_r;
  wire       txf_valid;
  wire [7:0] txf_data;
  usda_fifo #(.WIDTH(8), .DEPTH(`USDA_BUF_DEPTH), .AW(5)) u_tx_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .flush_i     (~fifo_en),
    .limit_i     (FIFO_LIM),
    .in_valid_i  (wr_slot & fifo_en),
    .in_ready_o  (),
    .in_data_i   (s_axi_wdata[`USDA_DATA_MSB:`USDA_DATA_LSB]),
    .out_valid_o (txf_valid),
    .out_ready_i (txf_take_r),
    .out_data_o  (txf_data),
    .count_o     ()
  );

  wire dr_flag = fifo_en ? rxf_valid : rx_hold_v_r;

  // receive holding and overrun; new event wins over read clear
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rx_hold_r   <= 8'h00;
      rx_hold_v_r <= 1'b0;
      overrun_r   <= 1'b0;
    end else begin
      if (rd_slot && !fifo_en)
        rx_hold_v_r <= 1'b0;
      if (rd_go && s_axi_araddr == `USDA_OFS_STAT)
        overrun_r <= 1'b0;
      if (rx_done_r && !fifo_en) begin
        rx_hold_r   <= rx_sh_r;
        rx_hold_v_r <= 1'b1;
        if (rx_hold_v_r && !rd_slot)
          overrun_r <= 1'b1;
      end
      if (rx_done_r && fifo_en && !rxf_in_ready)
        overrun_r <= 1'b1;
    end
  end

  // transmitter
  reg [1:0]  tx_st_r;
  reg [15:0] tx_cnt_r;
  reg [3:0]  tx_bit_r;
  reg [8:0]  tx_sh_r;
  wire       tx_src_v = fifo_en ? (txf_valid & ~txf_take_r) : ~transmit_holding_empty_flag_r;
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      tx_st_r      <= TXS_IDLE;
      tx_cnt_r     <= 16'h0000;
      tx_bit_r     <= 4'h0;
      tx_sh_r      <= 9'h1ff;
      txf_take_r   <= 1'b0;
      tx_hold_r    <= 8'h00;
      transmit_holding_empty_flag_r       <= 1'b1;
      serial_out_o <= 1'b1;
      ir_out_n_o   <= 1'b1;
    end else begin
      txf_take_r <= 1'b0;
      if (wr_slot && !fifo_en) begin
        tx_hold_r <= s_axi_wdata[`USDA_DATA_MSB:`USDA_DATA_LSB];
        transmit_holding_empty_flag_r    <= 1'b0;
      end
      case (tx_st_r)
        TXS_IDLE: begin
          if (tx_src_v && !(wr_slot && !fifo_en)) begin
            tx_sh_r    <= {fifo_en ? txf_data : tx_hold_r, 1'b0};
            tx_cnt_r   <= BIT_C - 16'h0001;
            tx_bit_r   <= 4'h0;
            tx_st_r    <= TXS_DATA;
            txf_take_r <= fifo_en;
            if (!fifo_en)
              transmit_holding_empty_flag_r <= 1'b1;
          end else if (fifo_en)
            transmit_holding_empty_flag_r <= ~txf_valid;
        end
        TXS_DATA: begin
          if (tx_cnt_r != 16'h0000)
            tx_cnt_r <= tx_cnt_r - 16'h0001;
          else begin
            tx_sh_r  <= {1'b1, tx_sh_r[8:1]};
            tx_cnt_r <= BIT_C - 16'h0001;
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == 4'h8)
              tx_st_r <= TXS_STOP;
          end
        end
        TXS_STOP: begin
          if (tx_cnt_r != 16'h0000)
            tx_cnt_r <= tx_cnt_r - 16'h0001;
          else
            tx_st_r <= TXS_IDLE;
        end
        default: tx_st_r <= TXS_IDLE;
      endcase
      // ir output is active low: idle high, a zero bit pulses low
      serial_out_o <= ir_mode ? 1'b1 : tx_sh_r[0];
      ir_out_n_o   <= ir_mode ? tx_sh_r[0] : 1'b1;
    end
  end

  // axi write channel: both address and data taken together
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      ctrl_r        <= `USDA_CTRL_RST;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (sel_slot(s_axi_awaddr))
          s_axi_bresp <= 2'b00;
        else if (s_axi_awaddr == `USDA_OFS_CTRL) begin
          s_axi_bresp <= 2'b00;
          if (s_axi_wstrb[0])
            ctrl_r <= {30'h00000000, s_axi_wdata[1:0]};
        end else
          s_axi_bresp <= 2'b10;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // axi read channel; one cycle answer
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        if (sel_slot(s_axi_araddr))
          s_axi_rdata <= {24'h000000, fifo_en ? rxf_data : rx_hold_r};
        else if (s_axi_araddr == `USDA_OFS_CTRL)
          s_axi_rdata <= ctrl_r;
        else if (s_axi_araddr == `USDA_OFS_STAT)
          s_axi_rdata <= {26'h0000000, transmit_holding_empty_flag_r, 3'h0, overrun_r, dr_flag};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // usda_core
`default_nettype wire

//--- tb/usda_core_sva.sv
// usda_core_sva.sv: bus handshake and serial line checks on the shadow data core
// assumes: bound to usda_core, one clock, synchronous active-low reset
`default_nettype none
module usda_core_sva #(
  parameter int BIT_CYC = 8
) (
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serial_out_o,
  input wire logic        ir_out_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] low_cnt_r;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // low run length; a run shorter than one bit means a broken baud count
  always @(posedge clk_sys_i) begin
    if (!reset_n_i || serial_out_o)
      low_cnt_r <= 16'h0;
    else
      low_cnt_r <= low_cnt_r + 16'h1;
  end
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
    |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
    else $error("write not answered next cycle");
  a_rd_answer: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered next cycle");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above the low byte");
  a_line_excl: assert property (!serial_out_o |-> ir_out_n_o)
    else $error("both line outputs active");
  a_bit_len: assert property ($rose(serial_out_o) |-> low_cnt_r >= BIT_CYC)
    else $error("serial low run shorter than a bit");
  a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_frame: cover property ($fell(serial_out_o));
endmodule // usda_core_sva
bind usda_core usda_core_sva #(.BIT_CYC(BIT_CYC)) usda_core_sva_inst (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .serial_out_o(serial_out_o),
  .ir_out_n_o(ir_out_n_o));
`default_nettype wire

//--- tb/usda_peer.sv
// usda_peer.sv: remote serial peer, sends frames and captures the core's frames
// assumes: 8N1 lsb first, BIT_CYC clocks a bit, lines idle high
`default_nettype none
module usda_peer #(
  parameter int BIT_CYC = 8
) (
  input  wire logic clk_sys_i,
  input  wire logic ir_sel_i,
  input  wire logic tx_line_i,
  input  wire logic ir_tx_n_i,
  output var logic  rx_line_o,
  output var logic  ir_rx_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got[$];
  wire logic line = ir_sel_i ? ir_tx_n_i : tx_line_i;
  initial begin
    rx_line_o = 1'b1;
    ir_rx_o = 1'b1;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      if (ir_sel_i) ir_rx_o <= f[i];
      else rx_line_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_sys_i);
    end
  endtask
  // a bit reads 0 if the line is low anywhere in it, so short ir pulses count
  always begin
    logic [7:0] b;
    @(negedge line);
    repeat (BIT_CYC) @(posedge clk_sys_i);
    for (int k = 0; k < 8; k++) begin
      b[k] = 1'b1;
      repeat (BIT_CYC) begin
        @(posedge clk_sys_i);
        b[k] = b[k] & line;
      end
    end
    got.push_back(b);
    repeat (BIT_CYC) @(posedge clk_sys_i);
  end
endmodule // usda_peer
`default_nettype wire

//--- tb/test_uart_shadow_data_access.sv
// test_uart_shadow_data_access.sv: self-checking bench for the shadow data core
// assumes: usda_map.vh on the include path, peer and checker compiled before
`default_nettype none
`include "usda_map.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e); end end
module test_uart_shadow_data_access;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BIT = 16;
  localparam logic [31:0] S7 = `USDA_OFS_SLOT7;
  localparam logic [31:0] S8 = `USDA_OFS_SLOT8;
  localparam logic [31:0] CT = `USDA_OFS_CTRL;
  localparam logic [31:0] ST = `USDA_OFS_STAT;
  logic clk_sys_i = 0, reset_n_i = 0, ir_sel = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, sin, irin, sout, irout;
  logic [1:0] bresp, rresp;
  int fail_count = 0, checks = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  usda_core #(.FIFO_DEPTH(16), .BIT_CYC(BIT)) usda_core_inst (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .serial_in_i(sin), .ir_in_i(irin),
    .serial_out_o(sout), .ir_out_n_o(irout));
  usda_peer #(.BIT_CYC(BIT)) usda_peer_inst (.clk_sys_i(clk_sys_i), .ir_sel_i(ir_sel),
    .tx_line_i(sout), .ir_tx_n_i(irout), .rx_line_o(sin), .ir_rx_o(irin));
  function automatic logic [1:0] resp_of(input logic [31:0] a);
    return (a == S7 || a == S8 || a == CT || a == ST) ? 2'b00 : 2'b10;
  endfunction
  // slow: ready is raised only once the answer shows, so the slave must hold it
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic slow = 1'b0);
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    {awvalid, wvalid} <= 2'b11;
    bready <= ~slow;
    do begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready === 1'b1));
    bready <= 1'b0;
    `CHK(bresp, resp_of(a))
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m,
                    input logic slow = 1'b0);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= ~slow;
    do begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready === 1'b1));
    rready <= 1'b0;
    `CHK(rresp, resp_of(a))
    `CHK(rdata & m, exp)
  endtask
  task automatic t_regs;
    rd(ST, 32'h20, 32'hffffffff, 1'b1);
    rd(S7, 32'h0, 32'hffffffff);
    wr(32'h50001190, 8'h5a, 1'b1);
    rd(32'h50001190, 32'h0, 32'hffffffff);
  endtask
  task automatic t_rx_plain;
    usda_peer_inst.send(8'ha5);
    repeat (3 * BIT) @(posedge clk_sys_i);
    rd(ST, 32'h21, 32'h23);
    rd(S7, 32'ha5, 32'hffffffff);
    usda_peer_inst.send(8'h3c);
    usda_peer_inst.send(8'hc3);
    repeat (3 * BIT) @(posedge clk_sys_i);
    rd(ST, 32'h23, 32'h23);
    rd(S8, 32'hc3, 32'hff);
    wr(CT, 8'h02);
    ir_sel <= 1'b1;
    @(posedge clk_sys_i);
    usda_peer_inst.send(8'h5a);
    repeat (3 * BIT) @(posedge clk_sys_i);
    rd(S7, 32'h5a, 32'hff);
  endtask
  // second write lands while the first shifts out, third must replace it
  task automatic t_tx_plain;
    wr(CT, 8'h00);
    ir_sel <= 1'b0;
    usda_peer_inst.got.delete();
    // low byte lane off: the slot write must neither load nor send anything
    wstrb <= 4'he;
    wr(S8, 8'h77);
    wstrb <= 4'hf;
    wr(S7, 8'h11);
    wr(S8, 8'h22);
    rd(ST, 32'h0, 32'h20);
    wr(S7, 8'h33);
    repeat (30 * BIT) @(posedge clk_sys_i);
    `CHK(usda_peer_inst.got.size(), 2)
    `CHK(usda_peer_inst.got[0], 8'h11)
    `CHK(usda_peer_inst.got[1], 8'h33)
    wr(CT, 8'h02);
    ir_sel <= 1'b1;
    wr(S7, 8'h96);
    repeat (12 * BIT) @(posedge clk_sys_i);
    `CHK(usda_peer_inst.got[2], 8'h96)
  endtask
  task automatic t_fifo;
    wr(CT, 8'h01);
    ir_sel <= 1'b0;
    usda_peer_inst.got.delete();
    for (int i = 0; i < 20; i++) wr(S7, 8'h60 + i[7:0]);
    repeat (200 * BIT) @(posedge clk_sys_i);
    `CHK(usda_peer_inst.got.size() < 18, 1'b1)
    for (int i = 0; i < 16; i++) `CHK(usda_peer_inst.got[i], 8'h60 + i[7:0])
    for (int i = 0; i < 17; i++) usda_peer_inst.send(8'h40 + i[7:0]);
    repeat (3 * BIT) @(posedge clk_sys_i);
    rd(ST, 32'h03, 32'h03);
    for (int i = 0; i < 16; i++) rd(S8, 32'h40 + i, 32'hff);
    rd(ST, 32'h0, 32'h01);
  endtask
  task automatic summarize;
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_rx_plain();
    t_tx_plain();
    t_fifo();
    summarize();
  end
  // whole run needs about 7500 cycles
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    fail_count++;
    summarize();
  end
endmodule // test_uart_shadow_data_access
`default_nettype wire
